/* lpps_pkg.sv */
`default_nettype none
package lpps_pkg;
  localparam int NUM_PINS = 8;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // register byte addresses
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_PULL = 8'h04;
  localparam logic [AXI_AW-1:0] REG_PADIN = 8'h08;
  localparam logic [AXI_AW-1:0] REG_MODE = 8'h0c;
  localparam int WORD_LSB = 2;

  // control register fields and resets
  localparam int CTRL_SPL_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam logic CTRL_SPL_RST = 1'b0;
  localparam logic CTRL_HOLD_RST = 1'b0;
  localparam logic [NUM_PINS-1:0] PULL_RST = 8'hff;
  localparam int MODE_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one-hot processor state bit positions
  localparam int CPU_POR = 0;
  localparam int CPU_XRST = 1;
  localparam int CPU_RUN = 2;
  localparam int CPU_SLEEP = 3;
  localparam int CPU_STBY = 4;
  localparam int CPU_DSTOP = 5;
  localparam int CPU_DRTC = 6;
  localparam int CPU_RET = 7;
  localparam int CPU_NUM = 8;

  typedef enum logic [3:0] {
    TYPE_A, TYPE_B, TYPE_C, TYPE_D, TYPE_E, TYPE_F,
    TYPE_G, TYPE_H, TYPE_I, TYPE_J, TYPE_K
  } lpps_type_t;

  typedef enum logic [3:0] {
    FN_XTAL, FN_EXT_CLK, FN_GPIO, FN_RST_IN, FN_BOOT_IN, FN_USB, FN_DEBUG_WIRE,
    FN_NMI, FN_WAKE, FN_ANALOG, FN_EXT_INT, FN_OTHER, FN_CEC
  } lpps_func_t;

  // pad-state table column
  typedef enum logic [2:0] {
    COL_POR, COL_XRST, COL_RUN, COL_STBY_HOLD, COL_STBY_FLOAT, COL_DEEP_HOLD, COL_DEEP_FLOAT, COL_RET_HOLD
  } lpps_col_t;

  typedef enum logic [MODE_W-1:0] {
    float_gated, float_live, float_reg_pull, float_clk_gated, xtal_halted, xtal_running,
    serial_port_active, serial_port_off, reg_controlled, reg_drive_no_pull, held_live,
    held_gated, snapshot_gated, input_pull_on, analog_only
  } lpps_mode_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull;
  } lpps_drive_t;

  typedef struct packed {
    lpps_type_t ptype;
    lpps_func_t func;
  } lpps_pin_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull;
    logic in_pass;
    logic osc_en;
    logic usb_own;
    logic ana_en;
  } lpps_pad_ctl_t;
endpackage
`default_nettype wire

/* lpps_pad_state.sv */
// Functional notes
// - float_gated: hi-z, no pull, input forced 0
// - float_live: hi-z, no pull, input passes
// - float_reg_pull: hi-z, pull from register, input passes
// - float_clk_gated: input passes only while oscillator runs
// - oscillator pins: halted hi-z, or running
// - usb pins: controller owns pad, else hi-z
// - reg_controlled: output and pull from registers
// - reg_drive_no_pull: register drives, pull always off
// - held_live: freeze drive, input passes
// - held_gated: freeze drive, input gated
// - snapshot_gated: drive captured gpio copy, input gated
// - standby gpio: held_live or float_gated by select
// - deep standby: held_gated/snapshot_gated or float_gated
// - after deep return, hold while release bit set
// - reset input: pull on, never gated
// - boot select input: no pull, never gated
// - oscillator function: input 0; hi-z, no pull except snapshot_gated for main-oscillator pins in deep hold
// - analog function: digital gated, analog always enabled
// - debug wire pull bit resets to one
// - wake pin stays float_reg_pull everywhere
// - ext interrupt: reg pull, deep snapshot or float
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`default_nettype none
module lpps_pad_state (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lpps_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lpps_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpps_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [lpps_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [lpps_pkg::CPU_NUM-1:0] cpu_state,
  input wire logic main_osc_running,
  input wire logic sub_osc_running,
  input wire lpps_pkg::lpps_pin_cfg_t pin_cfg [lpps_pkg::NUM_PINS],
  input wire lpps_pkg::lpps_drive_t gpio_drv [lpps_pkg::NUM_PINS],
  input wire lpps_pkg::lpps_drive_t periph_drv [lpps_pkg::NUM_PINS],
  input wire lpps_pkg::lpps_drive_t usb_drv [lpps_pkg::NUM_PINS],
  input wire logic [lpps_pkg::NUM_PINS-1:0] pad_in,
  output lpps_pkg::lpps_pad_ctl_t pad_ctl [lpps_pkg::NUM_PINS],
  output logic [lpps_pkg::NUM_PINS-1:0] core_in
);
  localparam int N = lpps_pkg::NUM_PINS;

  // table column from processor state and the two control bits
  function automatic lpps_pkg::lpps_col_t col_of(input logic [lpps_pkg::CPU_NUM-1:0] st, input logic standby_float_sel,
                                                 input logic hold);
    lpps_pkg::lpps_col_t c;
    c = lpps_pkg::COL_RUN;
    if (st[lpps_pkg::CPU_POR]) begin
      c = lpps_pkg::COL_POR;
    end else if (st[lpps_pkg::CPU_XRST]) begin
      c = lpps_pkg::COL_XRST;
    end else if (st[lpps_pkg::CPU_STBY]) begin
      c = standby_float_sel ? lpps_pkg::COL_STBY_FLOAT : lpps_pkg::COL_STBY_HOLD;
    end else if (st[lpps_pkg::CPU_DSTOP] || st[lpps_pkg::CPU_DRTC]) begin
      c = standby_float_sel ? lpps_pkg::COL_DEEP_FLOAT : lpps_pkg::COL_DEEP_HOLD;
    end else if (st[lpps_pkg::CPU_RET] && hold) begin
      c = lpps_pkg::COL_RET_HOLD;
    end
    return c;
  endfunction

  // pad state for one pin; unlisted cells fall back to float_gated
  function automatic lpps_pkg::lpps_mode_t mode_of(input lpps_pkg::lpps_pin_cfg_t cfg,
                                                   input lpps_pkg::lpps_col_t c);
    lpps_pkg::lpps_mode_t m;
    logic sub;
    logic early;
    logic deep;
    sub = (cfg.ptype == lpps_pkg::TYPE_C) || (cfg.ptype == lpps_pkg::TYPE_D);
    early = (c == lpps_pkg::COL_POR) || (c == lpps_pkg::COL_XRST);
    deep = (c == lpps_pkg::COL_DEEP_HOLD) || (c == lpps_pkg::COL_RET_HOLD);
    m = lpps_pkg::float_gated;
    case (cfg.func)
      lpps_pkg::FN_XTAL: begin
        if (c == lpps_pkg::COL_POR || (!sub && (c == lpps_pkg::COL_XRST || c == lpps_pkg::COL_RET_HOLD))) begin
          m = lpps_pkg::xtal_halted;
        end else if (!sub && c == lpps_pkg::COL_DEEP_HOLD) begin
          m = lpps_pkg::snapshot_gated;
        end else if (!sub && c == lpps_pkg::COL_DEEP_FLOAT) begin
          m = lpps_pkg::float_gated;
        end else begin
          m = lpps_pkg::xtal_running;
        end
      end
      lpps_pkg::FN_EXT_CLK: begin
        if (c == lpps_pkg::COL_RUN || c == lpps_pkg::COL_STBY_HOLD || c == lpps_pkg::COL_STBY_FLOAT) begin
          m = lpps_pkg::float_clk_gated;
        end
      end
      lpps_pkg::FN_GPIO: begin
        case (c)
          lpps_pkg::COL_POR: m = lpps_pkg::float_gated;
          lpps_pkg::COL_XRST: m = (cfg.ptype == lpps_pkg::TYPE_G || cfg.ptype == lpps_pkg::TYPE_I ||
                                   cfg.ptype == lpps_pkg::TYPE_K) ? lpps_pkg::float_live : lpps_pkg::float_gated;
          lpps_pkg::COL_RUN: m = (cfg.ptype == lpps_pkg::TYPE_G) ? lpps_pkg::reg_drive_no_pull :
                                 lpps_pkg::reg_controlled;
          lpps_pkg::COL_STBY_HOLD: m = lpps_pkg::held_live;
          lpps_pkg::COL_DEEP_HOLD,
          lpps_pkg::COL_RET_HOLD: begin
            if (cfg.ptype == lpps_pkg::TYPE_B) begin
              m = lpps_pkg::snapshot_gated;
            end else if (cfg.ptype == lpps_pkg::TYPE_I) begin
              m = lpps_pkg::float_gated;
            end else begin
              m = lpps_pkg::held_gated;
            end
          end
          default: m = lpps_pkg::float_gated;
        endcase
      end
      lpps_pkg::FN_RST_IN: m = lpps_pkg::input_pull_on;
      lpps_pkg::FN_BOOT_IN: m = lpps_pkg::float_live;
      lpps_pkg::FN_USB: m = (c == lpps_pkg::COL_RUN) ? lpps_pkg::serial_port_active :
                             lpps_pkg::serial_port_off;
      lpps_pkg::FN_DEBUG_WIRE: begin
        if (c == lpps_pkg::COL_POR) begin
          m = lpps_pkg::float_gated;
        end else if (c == lpps_pkg::COL_RUN) begin
          m = lpps_pkg::reg_controlled;
        end else begin
          m = lpps_pkg::float_reg_pull;
        end
      end
      lpps_pkg::FN_NMI: m = (!early && !deep && c != lpps_pkg::COL_DEEP_FLOAT) ? lpps_pkg::float_reg_pull :
                             lpps_pkg::float_gated;
      lpps_pkg::FN_WAKE: m = lpps_pkg::float_reg_pull;
      lpps_pkg::FN_ANALOG: m = lpps_pkg::analog_only;
      lpps_pkg::FN_EXT_INT: begin
        if (deep) begin
          m = lpps_pkg::snapshot_gated;
        end else if (c == lpps_pkg::COL_DEEP_FLOAT || early) begin
          m = lpps_pkg::float_gated;
        end else begin
          m = lpps_pkg::float_reg_pull;
        end
      end
      lpps_pkg::FN_CEC: m = lpps_pkg::reg_drive_no_pull;
      default: begin
        case (c)
          lpps_pkg::COL_RUN: m = lpps_pkg::reg_controlled;
          lpps_pkg::COL_STBY_HOLD: m = lpps_pkg::held_live;
          lpps_pkg::COL_DEEP_HOLD,
          lpps_pkg::COL_RET_HOLD: m = lpps_pkg::snapshot_gated;
          default: m = lpps_pkg::float_gated;
        endcase
      end
    endcase
    return m;
  endfunction

  // software-visible state
  logic standby_float_sel;
  logic hold_rel;
  logic [N-1:0] pull_en;

  wire lpps_pkg::lpps_col_t col = col_of(cpu_state, standby_float_sel, hold_rel);
  wire deep_now = cpu_state[lpps_pkg::CPU_DSTOP] | cpu_state[lpps_pkg::CPU_DRTC];

  lpps_pkg::lpps_mode_t mode_q [N];
  lpps_pkg::lpps_drive_t hold_drv [N];
  lpps_pkg::lpps_drive_t snap_drv [N];
  lpps_pkg::lpps_mode_t next_mode [N];
  lpps_pkg::lpps_pad_ctl_t next_ctl [N];

  // per-pin decode of the pad controls from the selected state
  for (genvar i = 0; i < N; i++) begin : g_pin
    wire lpps_pkg::lpps_drive_t own_drv = (pin_cfg[i].func == lpps_pkg::FN_GPIO) ? gpio_drv[i] : periph_drv[i];
    wire osc_run = ((pin_cfg[i].ptype == lpps_pkg::TYPE_C) || (pin_cfg[i].ptype == lpps_pkg::TYPE_D)) ?
                   sub_osc_running : main_osc_running;
    assign next_mode[i] = mode_of(pin_cfg[i], col);
    always_comb begin
      next_ctl[i] = '0;
      case (next_mode[i])
        lpps_pkg::float_live: next_ctl[i].in_pass = 1'b1;
        lpps_pkg::float_reg_pull: begin
          next_ctl[i].pull = pull_en[i];
          next_ctl[i].in_pass = 1'b1;
        end
        lpps_pkg::float_clk_gated: next_ctl[i].in_pass = osc_run;
        lpps_pkg::xtal_running: next_ctl[i].osc_en = 1'b1;
        lpps_pkg::serial_port_active: begin
          next_ctl[i].out = usb_drv[i].out;
          next_ctl[i].oe = usb_drv[i].oe;
          next_ctl[i].in_pass = 1'b1;
          next_ctl[i].usb_own = 1'b1;
        end
        lpps_pkg::reg_controlled: begin
          next_ctl[i].out = own_drv.out;
          next_ctl[i].oe = own_drv.oe;
          next_ctl[i].pull = own_drv.pull;
          next_ctl[i].in_pass = 1'b1;
        end
        lpps_pkg::reg_drive_no_pull: begin
          next_ctl[i].out = own_drv.out;
          next_ctl[i].oe = own_drv.oe;
          next_ctl[i].in_pass = 1'b1;
        end
        lpps_pkg::held_live,
        lpps_pkg::held_gated: begin
          next_ctl[i].out = hold_drv[i].out;
          next_ctl[i].oe = hold_drv[i].oe;
          next_ctl[i].pull = hold_drv[i].pull;
          next_ctl[i].in_pass = (next_mode[i] == lpps_pkg::held_live);
        end
        lpps_pkg::snapshot_gated: begin
          next_ctl[i].out = snap_drv[i].out;
          next_ctl[i].oe = snap_drv[i].oe;
          next_ctl[i].pull = snap_drv[i].pull;
        end
        lpps_pkg::input_pull_on: begin
          next_ctl[i].pull = 1'b1;
          next_ctl[i].in_pass = 1'b1;
        end
        lpps_pkg::analog_only: next_ctl[i].ana_en = 1'b1;
        default: next_ctl[i] = '0;
      endcase
    end

    // hold and snapshot copies track until their state is entered, then freeze
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode_q[i] <= lpps_pkg::float_gated;
        pad_ctl[i] <= '0;
        core_in[i] <= 1'b0;
        hold_drv[i] <= '0;
        snap_drv[i] <= '0;
      end else begin
        mode_q[i] <= next_mode[i];
        pad_ctl[i] <= next_ctl[i];
        core_in[i] <= pad_in[i] & next_ctl[i].in_pass;
        if (mode_q[i] != lpps_pkg::held_live && mode_q[i] != lpps_pkg::held_gated) begin
          hold_drv[i] <= '{out: pad_ctl[i].out, oe: pad_ctl[i].oe, pull: pad_ctl[i].pull};
        end
        if (mode_q[i] != lpps_pkg::snapshot_gated) begin
          snap_drv[i] <= gpio_drv[i];
        end
      end
    end
  end

  // axi4-lite write path: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [lpps_pkg::AXI_AW-1:0] aw_addr;
  logic [lpps_pkg::AXI_DW-1:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire [lpps_pkg::AXI_AW-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [lpps_pkg::AXI_DW-1:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_go = (aw_held | aw_take) & (w_held | w_take) & ~s_axi_bvalid;
  wire wr_ctrl = wr_go && wr_addr[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB] ==
                 lpps_pkg::REG_CTRL[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB] && wr_strb[0];
  wire wr_pull = wr_go && wr_addr[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB] ==
                 lpps_pkg::REG_PULL[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB] && wr_strb[0];
  wire wr_ok = (wr_addr[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB] ==
                lpps_pkg::REG_CTRL[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB]) ||
               (wr_addr[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB] ==
                lpps_pkg::REG_PULL[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB]);
  // deep standby re-arms the hold; this set beats a software clear in the same cycle
  wire next_hold = deep_now ? 1'b1 : (wr_ctrl ? wr_data[lpps_pkg::CTRL_HOLD_BIT] : hold_rel);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lpps_pkg::RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= wr_go ? 1'b0 : (aw_held | aw_take);
      w_held <= wr_go ? 1'b0 : (w_held | w_take);
      s_axi_awready <= wr_go ? 1'b0 : ~(aw_held | aw_take) & ~s_axi_bvalid;
      s_axi_wready <= wr_go ? 1'b0 : ~(w_held | w_take) & ~s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? lpps_pkg::RESP_OKAY : lpps_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_float_sel <= lpps_pkg::CTRL_SPL_RST;
      hold_rel <= lpps_pkg::CTRL_HOLD_RST;
      pull_en <= lpps_pkg::PULL_RST;
    end else begin
      hold_rel <= next_hold;
      if (wr_ctrl) begin
        standby_float_sel <= wr_data[lpps_pkg::CTRL_SPL_BIT];
      end
      if (wr_pull) begin
        pull_en <= wr_data[N-1:0];
      end
    end
  end

  // read path: one read outstanding at a time, zero above narrow fields
  logic [lpps_pkg::AXI_DW-1:0] mode_word;
  always_comb begin
    mode_word = '0;
    for (int k = 0; k < N; k++) begin
      mode_word[k*lpps_pkg::MODE_W +: lpps_pkg::MODE_W] = mode_q[k];
    end
  end
  wire [lpps_pkg::AXI_AW-lpps_pkg::WORD_LSB-1:0] rd_idx = s_axi_araddr[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB];
  wire rd_ctrl = rd_idx == lpps_pkg::REG_CTRL[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB];
  wire rd_pull = rd_idx == lpps_pkg::REG_PULL[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB];
  wire rd_padin = rd_idx == lpps_pkg::REG_PADIN[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB];
  wire rd_mode = rd_idx == lpps_pkg::REG_MODE[lpps_pkg::AXI_AW-1:lpps_pkg::WORD_LSB];
  logic [lpps_pkg::AXI_DW-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (rd_ctrl) begin
      rd_word[lpps_pkg::CTRL_SPL_BIT] = standby_float_sel;
      rd_word[lpps_pkg::CTRL_HOLD_BIT] = hold_rel;
    end else if (rd_pull) begin
      rd_word[N-1:0] = pull_en;
    end else if (rd_padin) begin
      rd_word[N-1:0] = core_in;
    end else if (rd_mode) begin
      rd_word = mode_word;
    end
  end
  wire rd_hit = rd_ctrl | rd_pull | rd_padin | rd_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= lpps_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? lpps_pkg::RESP_OKAY : lpps_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks on pins 0 to 5, each in the function the bench gives it, and the register bits
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_gated_zero: assert property (mode_q[0] == lpps_pkg::float_gated |->
    !pad_ctl[0].oe && !pad_ctl[0].pull && !core_in[0]) else $error("float_gated pad not quiet");
  chk_live_pass: assert property (mode_q[0] == lpps_pkg::float_live |->
    !pad_ctl[0].oe && core_in[0] == $past(pad_in[0])) else $error("float_live input not passed");
  chk_reg_pull: assert property (mode_q[0] == lpps_pkg::float_reg_pull |->
    pad_ctl[0].pull == $past(pull_en[0]) && !pad_ctl[0].oe) else $error("pull not from register");
  chk_nopull_drive: assert property (mode_q[0] == lpps_pkg::reg_drive_no_pull |->
    !pad_ctl[0].pull && pad_ctl[0].in_pass) else $error("no-pull state has pull");
  chk_held_frozen: assert property ((mode_q[0] == lpps_pkg::held_gated) && $past(mode_q[0]) == lpps_pkg::held_gated
    |-> $stable(pad_ctl[0].out) && $stable(pad_ctl[0].oe) && !core_in[0]) else $error("held drive moved");
  chk_snap_frozen: assert property (mode_q[5] == lpps_pkg::snapshot_gated [*2] |->
    $stable(pad_ctl[5].out) && !pad_ctl[5].in_pass) else $error("snapshot drive moved");
  chk_stby_select: assert property (cpu_state[lpps_pkg::CPU_STBY] && pin_cfg[0].func == lpps_pkg::FN_GPIO
    && pin_cfg[0].ptype == lpps_pkg::TYPE_A |=> mode_q[0] == ($past(standby_float_sel) ? lpps_pkg::float_gated :
    lpps_pkg::held_live)) else $error("standby gpio state wrong");
  chk_hold_rearm: assert property (deep_now |=> hold_rel ##1 (hold_rel || !$past(wr_ctrl)))
    else $error("hold bit not set in deep standby");
  chk_rst_pin: assert property (pin_cfg[1].func == lpps_pkg::FN_RST_IN |=>
    pad_ctl[1].pull && pad_ctl[1].in_pass && !pad_ctl[1].oe) else $error("reset pin not pulled up");
  chk_boot_pin: assert property (pin_cfg[2].func == lpps_pkg::FN_BOOT_IN |=>
    !pad_ctl[2].pull && pad_ctl[2].in_pass) else $error("boot pin wrong");
  chk_analog_on: assert property (pin_cfg[3].func == lpps_pkg::FN_ANALOG |=>
    pad_ctl[3].ana_en && !core_in[3] && !pad_ctl[3].oe) else $error("analog pin not isolated");
  chk_wake_pull: assert property (pin_cfg[4].func == lpps_pkg::FN_WAKE |=>
    mode_q[4] == lpps_pkg::float_reg_pull) else $error("wake pin left reg pull");
  chk_wr_resp: assert property (wr_go |=> s_axi_bvalid) else $error("write response missing");

  cov_stby_hold: cover property (mode_q[0] == lpps_pkg::held_live ##1 mode_q[0] == lpps_pkg::held_live);
  cov_deep_ret: cover property (deep_now ##1 cpu_state[lpps_pkg::CPU_RET] && hold_rel);
  cov_usb_own: cover property (pad_ctl[0].usb_own);
  cov_clk_gate: cover property (mode_q[0] == lpps_pkg::float_clk_gated && !pad_ctl[0].in_pass);
endmodule
`default_nettype wire

/* lpps_pads.sv */
`default_nettype none
// pad and pin-side model: drives what the pad wire would read back
module lpps_pads (
  input wire logic aclk,
  input wire lpps_pkg::lpps_pad_ctl_t pad_ctl [lpps_pkg::NUM_PINS],
  output logic [lpps_pkg::NUM_PINS-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wander = 1'b0;
  // an undriven, unpulled pad wanders so a stale level never passes for a real one
  always @(posedge aclk) begin
    wander <= ~wander;
  end
  // driven pad reads its own output, pulled pad reads high
  always_comb begin
    for (int k = 0; k < lpps_pkg::NUM_PINS; k++) begin
      if (pad_ctl[k].oe === 1'b1) pad_in[k] = pad_ctl[k].out;
      else if (pad_ctl[k].pull === 1'b1) pad_in[k] = 1'b1;
      else pad_in[k] = wander;
    end
  end
endmodule
`default_nettype wire

/* low_power_pad_state_test.sv */
`default_nettype none
module low_power_pad_state_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cpu_state, pad_in, core_in;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, main_osc_running, sub_osc_running;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  lpps_pkg::lpps_pin_cfg_t pin_cfg [lpps_pkg::NUM_PINS];
  lpps_pkg::lpps_drive_t gpio_drv [lpps_pkg::NUM_PINS];
  lpps_pkg::lpps_drive_t periph_drv [lpps_pkg::NUM_PINS];
  lpps_pkg::lpps_drive_t usb_drv [lpps_pkg::NUM_PINS];
  lpps_pkg::lpps_pad_ctl_t pad_ctl [lpps_pkg::NUM_PINS];
  int n_mismatch = 0;
  int total_checks = 0;
  lpps_pad_state DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cpu_state, .main_osc_running, .sub_osc_running, .pin_cfg, .gpio_drv, .periph_drv,
    .usb_drv, .pad_in, .pad_ctl, .core_in);
  lpps_pads PADS (.aclk, .pad_ctl, .pad_in);
  // 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pad(input logic [3:0] got, input logic [3:0] exp);
    cmp_reg({28'h0, got}, {28'h0, exp});
  endtask
  // each channel dropped on its own handshake; bready held until the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    cmp_reg(d & mask, exp);
    cmp_reg({30'h0, r}, {30'h0, (a > 8'h0c) ? lpps_pkg::RESP_SLVERR : lpps_pkg::RESP_OKAY});
  endtask
  // modes of pins 0 (gpio), 4 (wake), 5 (ext int), 7 (xtal) after settling
  task automatic go(input int st, input lpps_pkg::lpps_mode_t m0, m4, m5, m7);
    @(posedge aclk);
    cpu_state <= 8'h01 << st;
    repeat (3) @(posedge aclk);
    rd_chk(lpps_pkg::REG_MODE, 32'hf0ff000f, {m7, 4'h0, m5, m4, 12'h000, m0});
  endtask
  task automatic t_run();
    go(2, lpps_pkg::reg_controlled, lpps_pkg::float_reg_pull, lpps_pkg::float_reg_pull, lpps_pkg::xtal_running);
    cmp_pad({1'b0, pad_ctl[0].out, pad_ctl[0].oe, pad_ctl[0].pull}, 4'h6);
    cmp_pad({1'b0, pad_ctl[1].pull, pad_ctl[1].in_pass, core_in[1]}, 4'h7);
    cmp_pad({pad_ctl[2].oe, pad_ctl[2].pull, pad_ctl[2].in_pass, 1'b0}, 4'h2);
    cmp_pad({pad_ctl[3].ana_en, pad_ctl[3].in_pass, core_in[3], pad_ctl[3].pull}, 4'h8);
    cmp_pad({pad_ctl[7].osc_en, pad_ctl[7].oe, pad_ctl[7].pull, pad_ctl[7].in_pass}, 4'h8);
    cmp_pad({pad_ctl[4].oe, pad_ctl[4].pull, pad_ctl[4].in_pass, 1'b0}, 4'h6);
    axi_wr(lpps_pkg::REG_PULL, 32'h0000_00ef);
    repeat (3) @(posedge aclk);
    cmp_pad({pad_ctl[4].oe, pad_ctl[4].pull, pad_ctl[4].in_pass, 1'b0}, 4'h2);
  endtask
  task automatic t_standby();
    go(4, lpps_pkg::held_live, lpps_pkg::float_reg_pull, lpps_pkg::float_reg_pull, lpps_pkg::xtal_running);
    gpio_drv[0] <= '{1'b0, 1'b0, 1'b1};
    repeat (3) @(posedge aclk);
    cmp_pad({pad_ctl[0].in_pass, pad_ctl[0].out, pad_ctl[0].oe, pad_ctl[0].pull}, 4'he);
    axi_wr(lpps_pkg::REG_CTRL, 32'h1);
    go(4, lpps_pkg::float_gated, lpps_pkg::float_reg_pull, lpps_pkg::float_reg_pull, lpps_pkg::xtal_running);
    cmp_pad({pad_ctl[0].in_pass, pad_ctl[0].oe, pad_ctl[0].pull, core_in[0]}, 4'h0);
  endtask
  task automatic t_deep();
    go(5, lpps_pkg::float_gated, lpps_pkg::float_reg_pull, lpps_pkg::float_gated, lpps_pkg::float_gated);
    axi_wr(lpps_pkg::REG_CTRL, 32'h0);
    go(6, lpps_pkg::held_gated, lpps_pkg::float_reg_pull, lpps_pkg::snapshot_gated, lpps_pkg::snapshot_gated);
    cmp_pad({pad_ctl[0].in_pass, pad_ctl[5].in_pass, core_in[0], core_in[5]}, 4'h0);
    go(7, lpps_pkg::held_gated, lpps_pkg::float_reg_pull, lpps_pkg::snapshot_gated, lpps_pkg::xtal_halted);
    rd_chk(lpps_pkg::REG_CTRL, 32'hffff_ffff, 32'h2);
    axi_wr(lpps_pkg::REG_CTRL, 32'h0);
    go(7, lpps_pkg::reg_controlled, lpps_pkg::float_reg_pull, lpps_pkg::float_reg_pull, lpps_pkg::xtal_running);
    cmp_pad({1'b0, pad_ctl[0].out, pad_ctl[0].oe, pad_ctl[0].pull}, 4'h1);
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // run takes about a hundred cycles; a hang is cut well beyond that
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {main_osc_running, sub_osc_running, cpu_state} = {2'b11, 8'h01};
    gpio_drv = '{default: '0};
    periph_drv = '{default: '0};
    usb_drv = '{default: '0};
    gpio_drv[0] = '{1'b1, 1'b1, 1'b0};
    pin_cfg = '{'{lpps_pkg::TYPE_A, lpps_pkg::FN_GPIO}, '{lpps_pkg::TYPE_E, lpps_pkg::FN_RST_IN},
      '{lpps_pkg::TYPE_F, lpps_pkg::FN_BOOT_IN}, '{lpps_pkg::TYPE_J, lpps_pkg::FN_ANALOG},
      '{lpps_pkg::TYPE_I, lpps_pkg::FN_WAKE}, '{lpps_pkg::TYPE_J, lpps_pkg::FN_EXT_INT},
      '{lpps_pkg::TYPE_G, lpps_pkg::FN_DEBUG_WIRE}, '{lpps_pkg::TYPE_B, lpps_pkg::FN_XTAL}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(lpps_pkg::REG_CTRL, 32'hffff_ffff, 32'h0);
    rd_chk(lpps_pkg::REG_PULL, 32'hffff_ffff, 32'hff);
    rd_chk(8'h10, 32'hffff_ffff, 32'h0);
    go(0, lpps_pkg::float_gated, lpps_pkg::float_reg_pull, lpps_pkg::float_gated, lpps_pkg::xtal_halted);
    go(1, lpps_pkg::float_gated, lpps_pkg::float_reg_pull, lpps_pkg::float_gated, lpps_pkg::xtal_halted);
    t_run();
    t_standby();
    t_deep();
    print_verdict();
  end
endmodule
`default_nettype wire
